// File: rtl/power_switch_link.sv
/* Power switch serial link: downstream transmitter with selects, upstream
 * receiver with input mux and spike filter, fractional clock divider.
 * Assumes synchronous inputs on ref_clk; interrupt routing is outside. */
// Notes on behaviour
// - Fast synchronous downstream, slow asynchronous upstream channel.
// - Downstream uses eight lines: clock, data, selects.
// - Upstream input picked from eight by mux.
// - Each bit from registers or alternate buses.
// - Emergency stop forces chosen bits to preset values.
// - Service request pulses usable for interrupt or DMA.
// - Shift clock at most half module clock.
// - Module clock derived by fractional divider.
// - Command, data and passive frames supported.
// - Start by software, timer, or free-running.
// - Upstream frame length 16 or 12 bits.
// - Leading selection bit optional per configuration.
// - Chip selects show current transmission status.
// - Upstream baud is ref_clk over 8..512.
// - Asynchronous upstream frames checked for parity error.
// - Spike filter on upstream inputs before sampling.
`timescale 1ns/1ns
`default_nettype none
`include "power_switch_link_params.svh"
module power_switch_link
    import power_switch_link_pkg::*;
(
    // Clock and reset
    input  wire  logic                       ref_clk,
    input  wire  logic                       rst,
    // Divider and trigger configuration
    input  wire  logic [`FRAC_BITS-1:0]      frac_step,
    input  wire  logic [1:0]                 start_mode,
    input  wire  logic                       soft_start,
    input  wire  logic                       timer_event,
    input  wire  logic [1:0]                 frame_kind,
    input  wire  logic                       sel_bit_en,
    // Downstream data sources
    input  wire  logic [`DS_DATA_BITS-1:0]   data_reg,
    input  wire  logic [`DS_CMD_BITS-1:0]    cmd_reg,
    input  wire  logic [`DS_DATA_BITS-1:0]   alt_select,
    input  wire  logic [`DS_ALT_BITS-1:0]    alt_source_low,
    input  wire  logic [`DS_ALT_BITS-1:0]    alt_source_high,
    // Emergency stop
    input  wire  logic                       emergency_stop,
    input  wire  logic [`DS_DATA_BITS-1:0]   estop_mask,
    input  wire  logic [`DS_DATA_BITS-1:0]   estop_value,
    // Upstream configuration and lines
    input  wire  logic [7:0]                 upstream_serial_inputs,
    input  wire  logic [2:0]                 us_input_sel,
    input  wire  logic [2:0]                 us_div_code,
    input  wire  logic                       us_short_frame,
    input  wire  logic                       us_odd_parity,
    // Downstream pins
    output var   logic                       downstream_shift_clock,
    output var   logic                       ds_data,
    output var   logic [`DS_SELECTS-1:0]     ds_select,
    // Status and service requests
    output var   logic                       ds_busy,
    output var   logic                       ds_done_req,
    output var   logic [`US_LONG_BITS-1:0]   us_data,
    output var   logic                       us_rx_req,
    output var   logic                       us_parity_err
);
    localparam int FRAME_BITS = `DS_DATA_BITS + 1;
    // Bit source pick: alternate bus or register
    function automatic logic [`DS_DATA_BITS-1:0] pick_src(
        input logic [`DS_DATA_BITS-1:0] regv, altv, sel);
        pick_src = (altv & sel) | (regv & ~sel);
    endfunction : pick_src
    // Fractional divider state
    logic [`FRAC_BITS:0]       acc_r, acc_nxt;        // Phase accumulator
    logic                      tick_r, tick_nxt;      // Module clock tick
    // Fractional divider: tick on accumulator overflow
    always_comb begin
        logic [`FRAC_BITS:0] sum;
        sum      = acc_r + {1'b0, frac_step};
        tick_nxt = 1'b0;
        acc_nxt  = sum;
        if (sum >= `FRAC_FULL) begin
            tick_nxt = 1'b1;
            acc_nxt  = sum - `FRAC_FULL;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end
    // Downstream sequencer state
    ds_state_type              ds_st_r, ds_st_nxt;
    logic [FRAME_BITS-1:0]     shreg_r, shreg_nxt;     // Outgoing bits
    logic [5:0]                cnt_r, cnt_nxt;         // Bits remaining
    logic                      clk_r, clk_nxt;
    logic                      dat_r, dat_nxt;
    logic [`DS_SELECTS-1:0]    sel_r, sel_nxt;
    logic                      done_r, done_nxt;
    logic                      busy_r, busy_nxt;
    logic                      start_req;              // Start condition
    logic [`DS_DATA_BITS-1:0]  payload;                // Assembled data
    logic [`DS_DATA_BITS-1:0]  alt_word;
    assign alt_word = {alt_source_high, alt_source_low};
    // Start trigger and frame payload assembly
    always_comb begin
        unique case (start_mode_type'(start_mode))
            START_SOFT:  start_req = soft_start;
            START_TIMER: start_req = timer_event;
            START_FREE:  start_req = 1'b1;
            default:     start_req = 1'b0;             // Reserved code
        endcase
        // Register or alternate source per bit
        payload = pick_src(data_reg, alt_word, alt_select);
        // Emergency stop overrides chosen bits
        if (emergency_stop) begin
            payload = (payload & ~estop_mask) | (estop_value & estop_mask);
        end
    end
    // Downstream next state: low half then high half of each bit
    always_comb begin
        ds_st_nxt = ds_st_r;
        shreg_nxt = shreg_r;
        cnt_nxt   = cnt_r;
        clk_nxt   = clk_r;
        dat_nxt   = dat_r;
        sel_nxt   = sel_r;
        done_nxt  = 1'b0;
        busy_nxt  = busy_r;
        unique case (ds_st_r)
            DS_IDLE: begin
                clk_nxt = 1'b0;
                sel_nxt = '0;
                if (start_req && tick_r) begin
                    busy_nxt = 1'b1;
                    ds_st_nxt = DS_LOW;
                    // Frame kind sets content and select line
                    unique case (frame_kind_type'(frame_kind))
                        FRAME_CMD: begin
                            shreg_nxt = {1'b1, cmd_reg, 16'h0000};
                            cnt_nxt   = 6'(`DS_CMD_BITS);
                            sel_nxt   = 6'h02;
                        end
                        FRAME_DATA: begin
                            shreg_nxt = {1'b0, payload};
                            cnt_nxt   = 6'(`DS_DATA_BITS);
                            sel_nxt   = 6'h01;
                        end
                        default: begin                 // Passive frame
                            shreg_nxt = '0;
                            cnt_nxt   = 6'(`DS_DATA_BITS);
                        end
                    endcase
                    // Selection bit leads the frame when enabled
                    if (sel_bit_en) begin
                        cnt_nxt = cnt_nxt + 6'h01;
                    end else begin
                        shreg_nxt = {shreg_nxt[FRAME_BITS-2:0], 1'b0};
                    end
                    dat_nxt = shreg_nxt[FRAME_BITS-1];
                end
            end
            DS_LOW: begin
                // Rising edge at least one tick later: half rate max
                if (tick_r) begin
                    clk_nxt   = 1'b1;
                    ds_st_nxt = DS_HIGH;
                end
            end
            DS_HIGH: begin
                if (tick_r) begin
                    clk_nxt   = 1'b0;
                    shreg_nxt = {shreg_r[FRAME_BITS-2:0], 1'b0};
                    cnt_nxt   = cnt_r - 6'h01;
                    dat_nxt   = shreg_r[FRAME_BITS-2];
                    ds_st_nxt = DS_LOW;
                    if (cnt_r == 6'h01) begin
                        ds_st_nxt = DS_IDLE;
                        sel_nxt   = '0;
                        dat_nxt   = 1'b0;
                        busy_nxt  = 1'b0;
                        done_nxt  = 1'b1;
                    end
                end
            end
            default: ds_st_nxt = DS_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ds_st_r <= DS_IDLE;
            shreg_r <= '0;
            cnt_r   <= '0;
            clk_r   <= 1'b0;
            dat_r   <= 1'b0;
            sel_r   <= '0;
            done_r  <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            ds_st_r <= ds_st_nxt;
            shreg_r <= shreg_nxt;
            cnt_r   <= cnt_nxt;
            clk_r   <= clk_nxt;
            dat_r   <= dat_nxt;
            sel_r   <= sel_nxt;
            done_r  <= done_nxt;
            busy_r  <= busy_nxt;
        end
    end
    // Eight downstream lines: clock, data, six selects
    assign downstream_shift_clock = clk_r;
    assign ds_data     = dat_r;
    assign ds_select   = sel_r;
    assign ds_busy     = busy_r;
    assign ds_done_req = done_r;
    // Upstream front end state
    logic [`SPIKE_DEPTH-1:0]   hist_r, hist_nxt;      // Recent samples
    logic                      line_r, line_nxt;      // Filtered line
    logic [8:0]                pre_r, pre_nxt;        // Oversample counter
    logic                      os_r, os_nxt;          // Oversample strobe
    logic [8:0]                pre_lim;
    // Strobe every 1 << code cycles, 8 per bit: code 0..6 gives 8..512
    always_comb begin
        pre_lim = (us_div_code <= `US_DIV_MAX_CODE) ?
                  9'((10'h008 << us_div_code) >> 3) - 9'h001 : 9'h000;
        // Strobe and restart when the count reaches the limit
        os_nxt  = (pre_r >= pre_lim);
        pre_nxt = os_nxt ? 9'h000 : pre_r + 9'h001;
        // Mux then filter: change only on agreeing samples
        hist_nxt = {hist_r[`SPIKE_DEPTH-2:0],
                    upstream_serial_inputs[us_input_sel]};
        // Hold the line unless all samples agree
        line_nxt = (&hist_r) | (line_r & (|hist_r));
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hist_r <= '1;
            line_r <= 1'b1;
            pre_r  <= '0;
            os_r   <= 1'b0;
        end else begin
            hist_r <= hist_nxt;
            line_r <= line_nxt;
            pre_r  <= pre_nxt;
            os_r   <= os_nxt;
        end
    end
    // Upstream receiver state
    us_state_type              us_st_r, us_st_nxt;
    logic [2:0]                ph_r, ph_nxt;           // Phase of 8
    logic [4:0]                bit_r, bit_nxt;
    logic [`US_LONG_BITS-1:0]  sh_r, sh_nxt;
    logic                      par_r, par_nxt;
    logic [`US_LONG_BITS-1:0]  dout_r, dout_nxt;
    logic                      rxq_r, rxq_nxt;
    logic                      perr_r, perr_nxt;
    logic [4:0]                nbits;
    // Receiver: 8 samples per bit, centre at phase 3
    always_comb begin
        nbits     = us_short_frame ? 5'(`US_SHORT_BITS) : 5'(`US_LONG_BITS);
        us_st_nxt = us_st_r;
        ph_nxt    = ph_r;
        bit_nxt   = bit_r;
        sh_nxt    = sh_r;
        par_nxt   = par_r;
        dout_nxt  = dout_r;
        rxq_nxt   = 1'b0;
        perr_nxt  = 1'b0;
        if (os_r) begin
            ph_nxt = ph_r + 3'h1;
            unique case (us_st_r)
                US_IDLE: begin
                    ph_nxt = 3'h0;
                    if (!line_r) begin
                        us_st_nxt = US_START;
                    end
                end
                US_START: begin
                    if (ph_r == 3'h3) begin
                        us_st_nxt = line_r ? US_IDLE : US_BITS;
                        bit_nxt   = '0;
                        par_nxt   = us_odd_parity;
                        ph_nxt    = 3'h4;
                    end
                end
                US_BITS: begin
                    if (ph_r == 3'h3) begin
                        par_nxt = par_r ^ line_r;
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == nbits) begin
                            us_st_nxt = US_STOP;
                        end else begin                 // LSB first
                            sh_nxt = {line_r, sh_r[`US_LONG_BITS-1:1]};
                        end
                    end
                end
                US_STOP: begin
                    if (ph_r == 3'h3) begin
                        us_st_nxt = US_IDLE;
                        dout_nxt  = us_short_frame ? 16'(sh_r >> 4) : sh_r;
                        rxq_nxt   = 1'b1;
                        perr_nxt  = par_r | ~line_r;
                    end
                end
                default: us_st_nxt = US_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            us_st_r <= US_IDLE;
            ph_r    <= '0;
            bit_r   <= '0;
            sh_r    <= '0;
            par_r   <= 1'b0;
            dout_r  <= '0;
            rxq_r   <= 1'b0;
            perr_r  <= 1'b0;
        end else begin
            us_st_r <= us_st_nxt;
            ph_r    <= ph_nxt;
            bit_r   <= bit_nxt;
            sh_r    <= sh_nxt;
            par_r   <= par_nxt;
            dout_r  <= dout_nxt;
            rxq_r   <= rxq_nxt;
            perr_r  <= perr_nxt;
        end
    end
    assign us_data       = dout_r;
    assign us_rx_req     = rxq_r;
    assign us_parity_err = perr_r;
endmodule : power_switch_link
`default_nettype wire

// File: rtl/power_switch_link_params.svh
/*
 * Constants of the power switch serial link: frame sizes, divider widths,
 * filter depth and the largest upstream divider code.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef POWER_SWITCH_LINK_PARAMS_SVH
`define POWER_SWITCH_LINK_PARAMS_SVH

// Downstream output lines: clock, data, six selects
`define DS_LINES          8
`define DS_SELECTS        6
// Data frame payload width and alternate bus width
`define DS_DATA_BITS      32
`define DS_ALT_BITS       16
// Command frame payload width
`define DS_CMD_BITS       16
// Fractional divider accumulator width (step/1024)
`define FRAC_BITS         10
`define FRAC_FULL         11'h400
// Upstream frame lengths
`define US_LONG_BITS      16
`define US_SHORT_BITS     12
// Spike filter: line must agree this many samples
`define SPIKE_DEPTH       3
// Smallest oversampling divider exponent (divide by 8)
`define US_DIV_MIN_EXP    3
`define US_DIV_MAX_CODE   3'h6

`endif

// File: rtl/power_switch_link_pkg.sv
/*
 * Types of the power switch serial link.
 * Assumes the constants header is on the include path.
 */
`include "power_switch_link_params.svh"

package power_switch_link_pkg;

    // Downstream frame kinds
    typedef enum logic [1:0] {
        FRAME_PASSIVE = 2'b00,
        FRAME_DATA    = 2'b01,
        FRAME_CMD     = 2'b10
    } frame_kind_type;

    // Frame start trigger modes
    typedef enum logic [1:0] {
        START_SOFT  = 2'b00,
        START_TIMER = 2'b01,
        START_FREE  = 2'b10
    } start_mode_type;

    // Downstream sequencer states
    typedef enum logic [1:0] {
        DS_IDLE  = 2'b00,
        DS_LOW   = 2'b01,
        DS_HIGH  = 2'b10
    } ds_state_type;

    // Upstream receiver states
    typedef enum logic [1:0] {
        US_IDLE  = 2'b00,
        US_START = 2'b01,
        US_BITS  = 2'b10,
        US_STOP  = 2'b11
    } us_state_type;

endpackage : power_switch_link_pkg

// File: tb/power_switch_link_sva.sv
/* Checker for the power switch link's port behaviour.
   Assumes bind onto power_switch_link; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module power_switch_link_sva (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Controls watched
    input wire logic [1:0]  start_mode,
    input wire logic [1:0]  frame_kind,
    input wire logic        us_short_frame,
    // Outputs watched
    input wire logic        downstream_shift_clock,
    input wire logic [5:0]  ds_select,
    input wire logic        ds_busy,
    input wire logic        ds_done_req,
    input wire logic [15:0] us_data,
    input wire logic        us_rx_req,
    input wire logic        us_parity_err
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_idle_clk; !ds_busy |-> !downstream_shift_clock; endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("shift clock moves while idle");
    property p_sel_busy; |ds_select |-> ds_busy; endproperty
    a_sel_busy: assert property (p_sel_busy)
        else $error("select outside a frame");
    property p_one_sel; $onehot0(ds_select); endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("more than one select");
    property p_end; $fell(ds_busy) |-> ds_done_req && ds_select == 6'h00;
    endproperty
    a_end: assert property (p_end)
        else $error("frame end without done");
    property p_done; ds_done_req |=> !ds_done_req; endproperty
    a_done: assert property (p_done)
        else $error("done longer than a cycle");
    property p_kind; $rose(ds_busy) |-> ds_select ==
        ($past(frame_kind) == 2'h1 ? 6'h01 :
         $past(frame_kind) == 2'h2 ? 6'h02 : 6'h00);
    endproperty
    a_kind: assert property (p_kind)
        else $error("select does not match frame kind");
    property p_nostart; $rose(ds_busy) |-> $past(start_mode) != 2'h3;
    endproperty
    a_nostart: assert property (p_nostart)
        else $error("frame started with triggers off");
    property p_rx; us_rx_req |=> !us_rx_req; endproperty
    a_rx: assert property (p_rx)
        else $error("receive request longer than a cycle");
    property p_perr; us_parity_err |-> us_rx_req; endproperty
    a_perr: assert property (p_perr)
        else $error("parity flag without receive");
    property p_short; us_rx_req && us_short_frame |->
        us_data[15:12] == 4'h0; endproperty
    a_short: assert property (p_short)
        else $error("short frame wider than 12 bits");
    c_done: cover property (ds_done_req);
    c_rx: cover property (us_rx_req);
    c_perr: cover property (us_parity_err);
endmodule : power_switch_link_sva
bind power_switch_link power_switch_link_sva u_sva (.ref_clk, .rst,
    .start_mode, .frame_kind, .us_short_frame, .downstream_shift_clock,
    .ds_select, .ds_busy, .ds_done_req, .us_data, .us_rx_req,
    .us_parity_err);
`default_nettype wire

// File: tb/power_switch_model.sv
/* Far-side model: a power switch that captures downstream bits and
   sends upstream asynchronous frames. Assumes the link's ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module power_switch_model (
    // Clock and downstream pins
    input  wire logic       ref_clk,
    input  wire logic       sck,
    input  wire logic       sdat,
    input  wire logic [5:0] sel,
    // Upstream lines, idle high
    output var  logic [7:0] up_lines
);
    logic [63:0] word;  // Captured bits, newest in LSB
    int          nbits; // Bits captured this frame
    logic        sck_q; // Last shift clock
    logic        sel_q; // Last select activity
    initial up_lines = 8'hFF;
    // Take data on rising shift clock while a select is active
    always @(posedge ref_clk) begin
        if (|sel && !sel_q) begin
            word = '0;
            nbits = 0;
        end
        if (|sel && sck && !sck_q) begin
            word = {word[62:0], sdat};
            nbits++;
        end
        sck_q = sck;
        sel_q = |sel;
    end
    // Start, LSB-first data, parity, stop; others show the inverse
    task automatic send(input int ln, input logic [15:0] d,
                        input int n, input logic par, input int bt);
        logic [7:0] v;
        logic       b;
        for (int k = 0; k < n + 3; k++) begin
            b = (k == 0) ? 1'b0 : (k <= n) ? d[k-1] : (k == n + 1) ?
                par : 1'b1;
            for (int c = 0; c < bt; c++) begin
                @(posedge ref_clk);
                v = {8{~b}};
                // One-cycle spike early in each bit
                v[ln] = (c == 1) ? ~b : b;
                up_lines <= v;
            end
        end
        @(posedge ref_clk);
        up_lines <= 8'hFF;
    endtask : send
endmodule : power_switch_model
`default_nettype wire

// File: tb/tb.sv
/* Self-checking bench for the power switch link with a far-side model.
   Assumes the design package and constants header are compiled. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import power_switch_link_pkg::*;
    logic ref_clk, rst, soft_start, timer_event, sel_bit_en;
    logic emergency_stop, us_short_frame, us_odd_parity;
    logic [9:0] frac_step;
    logic [1:0] start_mode, frame_kind;
    logic [31:0] data_reg, alt_select, estop_mask, estop_value, mix;
    logic [15:0] cmd_reg, alt_source_low, alt_source_high, us_data, rx_d;
    logic [2:0] us_input_sel, us_div_code;
    logic [5:0] ds_select;
    logic downstream_shift_clock, ds_data, ds_busy, ds_done_req;
    logic us_rx_req, us_parity_err, rx_e;
    wire logic [7:0] upstream_serial_inputs;
    int err_count, cmp_count, rx_n, cnt;
    power_switch_link DUT (.ref_clk, .rst, .frac_step, .start_mode,
        .soft_start, .timer_event, .frame_kind, .sel_bit_en, .data_reg,
        .cmd_reg, .alt_select, .alt_source_low, .alt_source_high,
        .emergency_stop, .estop_mask, .estop_value,
        .upstream_serial_inputs, .us_input_sel, .us_div_code,
        .us_short_frame, .us_odd_parity, .downstream_shift_clock,
        .ds_data, .ds_select, .ds_busy, .ds_done_req, .us_data,
        .us_rx_req, .us_parity_err);
    power_switch_model M (.ref_clk, .sck(downstream_shift_clock),
        .sdat(ds_data), .sel(ds_select), .up_lines(upstream_serial_inputs));
    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Record every received upstream word
    always @(posedge ref_clk) begin
        if (us_rx_req === 1'b1) begin
            rx_n++;
            rx_d = us_data;
            rx_e = us_parity_err;
        end
    end
    task automatic final_report;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic chk_word(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    // Bounded wait for busy (w=0) or done pulse (w=1); cnt gets cycles
    task automatic wait_on(input int w);
        for (cnt = 1; cnt < 4000; cnt++) begin
            @(posedge ref_clk);
            if ((w == 0 ? ds_busy : ds_done_req) === 1'b1) return;
        end
        err_count++;
        final_report();
    endtask : wait_on
    // Soft-started frame, bit count and bits compared
    task automatic frame(input logic [1:0] k, input logic sb, input int n,
                         input logic [63:0] e);
        frame_kind <= k;
        sel_bit_en <= sb;
        M.nbits = 0;
        @(posedge ref_clk);
        soft_start <= 1'b1;
        wait_on(0);
        soft_start <= 1'b0;
        wait_on(1);
        chk_word(M.nbits, n);
        if (n > 0) chk_word(M.word, e);
    endtask : frame
    // Timer mode ignores soft start; frame length follows the divider
    task automatic timer_go;
        logic seen;
        seen = 1'b0;
        start_mode <= 2'h1;
        frac_step <= 10'h100;
        soft_start <= 1'b1;
        repeat (40) begin
            @(posedge ref_clk);
            if (ds_busy !== 1'b0) seen = 1'b1;
        end
        chk_word(seen, 0);
        soft_start <= 1'b0;
        timer_event <= 1'b1;
        wait_on(0);
        timer_event <= 1'b0;
        wait_on(1);
        chk_word(cnt >= 248 && cnt <= 264, 1);
        frac_step <= 10'h200;
    endtask : timer_go
    // Free running restarts at once; mode 3 stops it
    task automatic free_go;
        logic seen;
        seen = 1'b0;
        start_mode <= 2'h2;
        wait_on(1);
        repeat (4) @(posedge ref_clk);
        chk_word(ds_busy, 1);
        start_mode <= 2'h3;
        wait_on(1);
        repeat (200) begin
            @(posedge ref_clk);
            if (ds_busy !== 1'b0) seen = 1'b1;
        end
        chk_word(seen, 0);
        start_mode <= 2'h0;
    endtask : free_go
    // One upstream frame on line ln at divider code cd
    task automatic up(input int ln, input int cd, input logic sh,
                      input logic od, input logic bad, input logic [15:0] d);
        logic [15:0] e;
        int n0;
        us_input_sel <= ln[2:0];
        us_div_code <= cd[2:0];
        us_short_frame <= sh;
        us_odd_parity <= od;
        e = sh ? {4'h0, d[11:0]} : d;
        n0 = rx_n;
        @(posedge ref_clk);
        M.send(ln, e, sh ? 12 : 16, ^e ^ od ^ bad, 8 << cd);
        repeat (16 << cd) @(posedge ref_clk);
        chk_word(rx_n - n0, 1);
        chk_word(rx_d, e);
        chk_word(rx_e, bad);
    endtask : up
    // Main sequence
    initial begin
        {soft_start, timer_event, sel_bit_en, emergency_stop} = 4'h0;
        {us_short_frame, us_odd_parity, start_mode, frame_kind} = 6'h00;
        {us_input_sel, us_div_code} = 6'h00;
        frac_step = 10'h200;
        data_reg = 32'hA5C3_0F81;
        cmd_reg = 16'h9C35;
        alt_select = 32'h0;
        {alt_source_high, alt_source_low} = 32'h3C5A_F00F;
        estop_mask = 32'h8000_0001;
        estop_value = 32'h0000_0001;
        rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        frame(2'h1, 1'b0, 32, {32'h0, data_reg});
        alt_select <= 32'hFF00_00F0;
        mix = (data_reg & ~32'hFF00_00F0) | (32'h3C5A_F00F & 32'hFF00_00F0);
        frame(2'h1, 1'b1, 33, {32'h0, mix});
        emergency_stop <= 1'b1;
        mix = (mix & ~estop_mask) | (estop_value & estop_mask);
        frame(2'h1, 1'b0, 32, {32'h0, mix});
        emergency_stop <= 1'b0;
        frame(2'h2, 1'b1, 17, {47'h0, 1'b1, cmd_reg});
        frame(2'h2, 1'b0, 16, {48'h0, cmd_reg});
        frame(2'h0, 1'b0, 0, 64'h0);
        timer_go();
        free_go();
        for (int i = 0; i < 8; i++)
            up(i, 0, 1'b0, 1'b0, 1'b0, 16'hB36D ^ i);
        for (int c = 1; c < 7; c++)
            up(5, c, 1'b1, 1'b1, 1'b0, 16'h0A5C);
        up(2, 0, 1'b1, 1'b0, 1'b1, 16'h0F31);
        final_report();
    end
endmodule : tb
`default_nettype wire
